// ---- rtl/sdc_pkg.sv ----
// shared constants, command codes and carriers of the sdram control word block
package sdc_pkg;
	localparam int SDC_REGIONS = 4;
	localparam int SDC_REG_W = 2;
	localparam int SDC_RA_W = 4;
	localparam logic [SDC_RA_W-1:0] SDC_CTL_OFS = 4'h0;
	localparam int SDC_RET_BIT = 0;
	localparam int SDC_TRC_LSB = 12;
	localparam int SDC_TRP_LSB = 16;
	localparam int SDC_ACT_TO_COLUMN_DELAY_FIELD_LSB = 20;
	localparam int SDC_INIT_BIT = 24;
	localparam int SDC_REFRESH_ON_BIT_BIT = 25;
	localparam int SDC_LWID_BIT = 26;
	localparam int SDC_CSZ_LSB = 26;
	localparam int SDC_RSZ_LSB = 28;
	localparam int SDC_BSZ_BIT = 30;
	localparam int SDC_PALL_BIT = 10;
	localparam logic [31:0] SDC_WMASK_NEW = 32'h7EFF_F001;
	localparam logic [31:0] SDC_WMASK_OLD = 32'h06FF_F000;
	localparam logic [31:0] SDC_RST_NEW = 32'h0248_F000;
	localparam logic [31:0] SDC_RST_OLD = 32'h0288_F000;
	localparam logic SDC_INIT_RST = 1'b1;
	localparam logic [3:0] SDC_MRS_WAIT = 4'h1;
	localparam logic [12:0] SDC_MODE_WORD = 13'h0022;
	localparam logic [3:0] SDC_COLS_8 = 4'h8;
	localparam logic [3:0] SDC_COLS_9 = 4'h9;
	localparam logic [3:0] SDC_COLS_10 = 4'hA;
	localparam logic [3:0] SDC_ROWS_11 = 4'hB;
	localparam logic [3:0] SDC_ROWS_12 = 4'hC;
	localparam logic [3:0] SDC_ROWS_13 = 4'hD;

	typedef enum logic [2:0] {
		SDC_NOP  = 3'b000,
		SDC_ACT  = 3'b001,
		SDC_RD   = 3'b010,
		SDC_WR   = 3'b011,
		SDC_PALL = 3'b100,
		SDC_REF  = 3'b101,
		SDC_MRS  = 3'b110,
		SDC_SELF = 3'b111
	} sdc_cmd_e;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_INIT_RF1 = 4'b0001,
		ST_INIT_RF2 = 4'b0010,
		ST_INIT_MRS = 4'b0011,
		ST_INIT_END = 4'b0100,
		ST_COL      = 4'b0101,
		ST_CLOSE    = 4'b0110,
		ST_SR_ENTER = 4'b0111,
		ST_SELF     = 4'b1000
	} sdc_state_e;

	typedef struct packed {
		sdc_cmd_e               cmd;
		logic [SDC_REGIONS-1:0] cs;
		logic [1:0]             bank;
		logic [12:0]            addr;
	} sdc_cmd_s;

	typedef struct packed {
		logic       legacy;
		logic       lwid;
		logic [1:0] csz;
		logic [1:0] rsz;
		logic       bsz;
	} sdc_geom_s;
endpackage

// ---- rtl/sdc_addr_map.sv ----
// splits a linear word address into column, bank and row by the geometry setting
`timescale 1ns/100ps
`default_nettype none
module sdc_addr_map (
	input  wire sdc_pkg::sdc_geom_s geom,
	input  wire logic [31:0]        lin_addr,
	output logic [9:0]              col,
	output logic [1:0]              bank,
	output logic [12:0]             row
);
	import sdc_pkg::*;

	logic [3:0]  ncol;
	logic [3:0]  nrow;
	logic [3:0]  nbank;
	logic [31:0] upper;

	always_comb begin
		ncol = SDC_COLS_9;
		nrow = SDC_ROWS_11;
		nbank = 4'h1;
		if (geom.legacy) begin
			ncol = geom.lwid ? SDC_COLS_8 : SDC_COLS_9;
		end else begin
			case (geom.csz)
				2'b01: ncol = SDC_COLS_8;
				2'b10: ncol = SDC_COLS_10;
				default: ncol = SDC_COLS_9;
			endcase
			case (geom.rsz)
				2'b01: nrow = SDC_ROWS_12;
				2'b10: nrow = SDC_ROWS_13;
				default: nrow = SDC_ROWS_11;
			endcase
			nbank = geom.bsz ? 4'h2 : 4'h1;
		end
		upper = lin_addr >> ncol;
		col = 10'(lin_addr & ((32'h1 << ncol) - 32'h1));
		bank = 2'(upper & ((32'h1 << nbank) - 32'h1));
		row = 13'((upper >> nbank) & ((32'h1 << nrow) - 32'h1));
	end
endmodule
`default_nettype wire

// ---- rtl/sdc_ctrl.sv ----
// sdram control word register with init, refresh, access and self-refresh sequencing
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - one control word serves every region marked as sdram alike.
// - bits 15..12 hold row cycle time as cycles minus one, reset 1111.
// - bits 19..16 hold precharge time as cycles minus one, reset 1000.
// - bits 23..20 set row-open to column spacing; write data leads by one.
// - init bit reads one after reset and clears fast with no sdram.
// - bit 25 enables periodic refresh, reset one.
// - legacy bit 26 picks 9 column pins when zero, 8 when one.
// - column code 00 is 9 pins, 01 is 8, 10 is 10, 11 reserved.
// - row code 00 is 11 pins, 01 is 12, 10 is 13, 11 reserved.
// - bit 30 picks one bank pin when zero, two when one.
// - retention bit with sdram present puts the memory into self-refresh.
// - without sdram the retention bit drives clock enable inverted.
// - second instance keeps bit 0 as plain storage, reset zero.
module sdc_ctrl #(
	parameter bit FIRST_INST = 1'b1,
	parameter bit LEGACY     = 1'b0
) (
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic [sdc_pkg::SDC_RA_W-1:0] reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [31:0]                      reg_rdata,
	input  wire logic [sdc_pkg::SDC_REGIONS-1:0] region_sdram,
	input  wire logic                        refresh_tick,
	input  wire logic                        acc_req,
	input  wire logic                        acc_write,
	input  wire logic [sdc_pkg::SDC_REG_W-1:0] acc_region,
	input  wire logic [31:0]                 acc_addr,
	output logic                             acc_ack,
	output logic                             wr_lead,
	output var sdc_pkg::sdc_cmd_s            mem_cmd,
	output logic                             mem_cke
);
	import sdc_pkg::*;

	localparam logic [31:0] WMASK = LEGACY ? SDC_WMASK_OLD : SDC_WMASK_NEW;
	localparam logic [31:0] RST_VAL = LEGACY ? SDC_RST_OLD : SDC_RST_NEW;
	localparam logic [31:0] RMASK = WMASK | (32'h1 << SDC_INIT_BIT);

	if ((1 << SDC_REG_W) < SDC_REGIONS) begin : g_chk
		$error("region select too narrow for the region count");
	end

	sdc_state_e             state;
	logic [3:0]             cnt;
	logic [31:0]            ctl;
	logic                   init;
	logic                   ref_pend;
	logic [9:0]             col_q;
	logic [SDC_REGIONS-1:0] acc_cs;
	logic [1:0]             bank_q;
	logic                   acc_wr_q;
	logic [3:0]             row_cycle_time_field;
	logic [3:0]             precharge_time_field;
	logic [3:0]             act_to_column_delay_field;
	logic                   refresh_on_bit;
	logic                   ret_want;
	logic                   sdram_any;
	logic                   ctl_hit;
	logic                   idle;
	logic                   go_init;
	logic                   go_sr;
	logic                   go_ref;
	logic                   go_act;
	logic                   col_go;
	logic                   init_clr;
	sdc_geom_s              geom;
	logic [9:0]             map_col;
	logic [1:0]             map_bank;
	logic [12:0]            map_row;

	assign row_cycle_time_field = ctl[SDC_TRC_LSB +: 4];
	assign precharge_time_field = ctl[SDC_TRP_LSB +: 4];
	assign act_to_column_delay_field = ctl[SDC_ACT_TO_COLUMN_DELAY_FIELD_LSB +: 4];
	assign refresh_on_bit = ctl[SDC_REFRESH_ON_BIT_BIT];
	// retention only on the first instance
	assign ret_want = FIRST_INST && ctl[SDC_RET_BIT];
	// any sdram region enables the sequencer
	assign sdram_any = |region_sdram;
	assign ctl_hit = reg_addr == SDC_CTL_OFS;

	assign geom.legacy = LEGACY;
	assign geom.lwid = ctl[SDC_LWID_BIT];
	assign geom.csz = ctl[SDC_CSZ_LSB +: 2];
	assign geom.rsz = ctl[SDC_RSZ_LSB +: 2];
	assign geom.bsz = ctl[SDC_BSZ_BIT];

	sdc_addr_map u_map (
		.geom     (geom),
		.lin_addr (acc_addr),
		.col      (map_col),
		.bank     (map_bank),
		.row      (map_row)
	);

	assign idle = (state == ST_IDLE) && (cnt == 4'h0);
	assign go_init = idle && init && sdram_any;
	assign go_sr = idle && !init && ret_want && sdram_any;
	assign go_ref = idle && !init && !ret_want && ref_pend && refresh_on_bit && sdram_any;
	assign go_act = idle && !init && !ret_want && !(ref_pend && refresh_on_bit)
		&& acc_req && region_sdram[acc_region];
	assign col_go = (state == ST_COL) && (cnt == 4'h0);
	// no sdram region means nothing to initialise
	assign init_clr = ((state == ST_INIT_END) && (cnt == 4'h0))
		|| (idle && init && !sdram_any);
	assign acc_ack = col_go;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctl <= RST_VAL;
		end else if (reg_wr && ctl_hit) begin
			ctl <= (ctl & ~WMASK) | (reg_wdata & WMASK);
		end
	end

	// a written one wins over the self-clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			init <= SDC_INIT_RST;
		end else if (reg_wr && ctl_hit && reg_wdata[SDC_INIT_BIT]) begin
			init <= 1'b1;
		end else if (init_clr) begin
			init <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd && ctl_hit) begin
			reg_rdata <= (ctl & WMASK) | (32'(init) << SDC_INIT_BIT);
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// tick sets even while the served pending is cleared
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ref_pend <= 1'b0;
		end else if (refresh_tick) begin
			ref_pend <= 1'b1;
		end else if (go_ref || !refresh_on_bit || state == ST_SELF) begin
			ref_pend <= 1'b0;
		end
	end

	// geometry is captured when the row opens
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			col_q <= 10'h000;
			acc_cs <= '0;
			acc_wr_q <= 1'b0;
			bank_q <= 2'h0;
		end else if (go_act) begin
			col_q <= map_col;
			acc_cs <= SDC_REGIONS'(1) << acc_region;
			acc_wr_q <= acc_write;
			bank_q <= map_bank;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			cnt <= 4'h0;
			mem_cmd <= '0;
		end else begin
			mem_cmd <= '0;
			if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else begin
				case (state)
					ST_IDLE: begin
						if (go_init || go_sr) begin
							mem_cmd.cmd <= SDC_PALL;
							mem_cmd.cs <= region_sdram;
							mem_cmd.addr[SDC_PALL_BIT] <= 1'b1;
							cnt <= precharge_time_field;
							state <= go_init ? ST_INIT_RF1 : ST_SR_ENTER;
						end else if (go_ref) begin
							mem_cmd.cmd <= SDC_REF;
							mem_cmd.cs <= region_sdram;
							cnt <= row_cycle_time_field;
						end else if (go_act) begin
							mem_cmd.cmd <= SDC_ACT;
							mem_cmd.cs <= SDC_REGIONS'(1) << acc_region;
							mem_cmd.bank <= map_bank;
							mem_cmd.addr <= map_row;
							cnt <= act_to_column_delay_field;
							state <= ST_COL;
						end
					end
					ST_INIT_RF1, ST_INIT_RF2: begin
						mem_cmd.cmd <= SDC_REF;
						mem_cmd.cs <= region_sdram;
						cnt <= row_cycle_time_field;
						state <= (state == ST_INIT_RF1) ? ST_INIT_RF2 : ST_INIT_MRS;
					end
					ST_INIT_MRS: begin
						mem_cmd.cmd <= SDC_MRS;
						mem_cmd.cs <= region_sdram;
						mem_cmd.addr <= SDC_MODE_WORD;
						cnt <= SDC_MRS_WAIT;
						state <= ST_INIT_END;
					end
					ST_INIT_END: begin
						state <= ST_IDLE;
					end
					ST_COL: begin
						mem_cmd.cmd <= acc_wr_q ? SDC_WR : SDC_RD;
						mem_cmd.cs <= acc_cs;
						mem_cmd.bank <= bank_q;
						mem_cmd.addr <= {3'b000, col_q};
						cnt <= row_cycle_time_field;
						state <= ST_CLOSE;
					end
					ST_CLOSE: begin
						mem_cmd.cmd <= SDC_PALL;
						mem_cmd.cs <= acc_cs;
						mem_cmd.addr[SDC_PALL_BIT] <= 1'b1;
						cnt <= precharge_time_field;
						state <= ST_IDLE;
					end
					ST_SR_ENTER: begin
						mem_cmd.cmd <= SDC_SELF;
						mem_cmd.cs <= region_sdram;
						state <= ST_SELF;
					end
					ST_SELF: begin
						if (!ret_want || !sdram_any) begin
							cnt <= row_cycle_time_field;
							state <= ST_IDLE;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// write data one cycle ahead of the column write
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_lead <= 1'b0;
		end else begin
			wr_lead <= ((state == ST_COL) && (cnt == 4'h1) && acc_wr_q)
				|| (go_act && (act_to_column_delay_field == 4'h0) && acc_write);
		end
	end

	// clock enable as plain output without sdram
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mem_cke <= 1'b1;
		end else if (sdram_any) begin
			mem_cke <= !(((state == ST_SR_ENTER) && (cnt == 4'h0))
				|| ((state == ST_SELF) && ret_want));
		end else begin
			mem_cke <= !ret_want;
		end
	end

	logic [4:0] act_age;
	logic [3:0] act_to_column_delay_field_q;
	logic       two_banks_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			act_age <= 5'h1F;
			act_to_column_delay_field_q <= 4'h0;
			two_banks_q <= 1'b0;
		end else if (go_act) begin
			act_age <= 5'h00;
			act_to_column_delay_field_q <= act_to_column_delay_field;
			two_banks_q <= !LEGACY && geom.bsz;
		end else if (act_age != 5'h1F) begin
			act_age <= act_age + 5'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	ref_cs_a: assert property (mem_cmd.cmd == SDC_REF |-> mem_cmd.cs == $past(region_sdram))
		else $error("refresh not sent to all sdram regions");
	pall_gap_a: assert property (mem_cmd.cmd == SDC_PALL && precharge_time_field != 4'h0
		|=> mem_cmd.cmd == SDC_NOP)
		else $error("command right after precharge all");
	act_sep_a: assert property ((mem_cmd.cmd == SDC_RD || mem_cmd.cmd == SDC_WR)
		|-> act_age == {1'b0, act_to_column_delay_field_q} + 5'h01)
		else $error("row open to column spacing wrong");
	wlead_a: assert property (wr_lead |=> mem_cmd.cmd == SDC_WR)
		else $error("write data lead not followed by write");
	init_seq_a: assert property (go_init
		|=> mem_cmd.cmd == SDC_PALL && state == ST_INIT_RF1)
		else $error("init did not start with precharge all");
	init_clear_a: assert property (idle && init && !sdram_any && !reg_wr |=> !init)
		else $error("init bit not cleared without sdram");
	ref_gate_a: assert property (mem_cmd.cmd == SDC_REF && !init |-> $past(refresh_on_bit))
		else $error("refresh issued while disabled");
	bank_one_a: assert property (mem_cmd.cmd == SDC_ACT && !two_banks_q
		|-> mem_cmd.bank[1] == 1'b0)
		else $error("second bank pin used with one bank pin");
	self_cke_a: assert property (state == ST_SELF |-> !mem_cke)
		else $error("clock enable high in self-refresh");
	cke_gpo_a: assert property (FIRST_INST && !$past(sdram_any)
		|-> mem_cke == !$past(ctl[SDC_RET_BIT]))
		else $error("clock enable output does not follow retention bit");
	inst_cke_a: assert property (FIRST_INST || mem_cke)
		else $error("second instance dropped clock enable");
	rsv_read_a: assert property ($past(reg_rd) |-> (reg_rdata & ~RMASK) == 32'h0)
		else $error("reserved bits read nonzero");

	init_done_c: cover property (state == ST_INIT_END ##1 !init);
	self_ref_c: cover property (state == ST_SELF ##1 state == ST_IDLE);
	write_acc_c: cover property (wr_lead ##1 mem_cmd.cmd == SDC_WR);
	refresh_c: cover property (go_ref);
endmodule
`default_nettype wire

// ---- tb/sdc_mem_model.sv ----
// sdram partner that logs when each command appears on the pins
`timescale 1ns/100ps
`default_nettype none
module sdc_mem_model (
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire sdc_pkg::sdc_cmd_s mem_cmd,
	input  wire logic              mem_cke,
	input  wire logic              wr_lead,
	output logic [15:0]            t_last [8],
	output var sdc_pkg::sdc_cmd_s  c_last [8],
	output logic [7:0]             n_cmd [8],
	output logic [15:0]            t_lead,
	output logic                   in_self
);
	import sdc_pkg::*;
	logic [15:0] cyc;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cyc <= 16'h0000;
			t_lead <= 16'h0000;
			for (int i = 0; i < 8; i++) begin
				n_cmd[i] <= 8'h00;
				t_last[i] <= 16'h0000;
				c_last[i] <= '0;
			end
		end else begin
			cyc <= cyc + 16'h0001;
			if (wr_lead)
				t_lead <= cyc;
			if (mem_cmd.cmd != SDC_NOP) begin
				t_last[mem_cmd.cmd] <= cyc;
				c_last[mem_cmd.cmd] <= mem_cmd;
				n_cmd[mem_cmd.cmd] <= n_cmd[mem_cmd.cmd] + 8'h01;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst || mem_cke)
			in_self <= 1'b0;
		else if (mem_cmd.cmd == SDC_SELF)
			in_self <= 1'b1;
	end
endmodule
`default_nettype wire

// ---- tb/sdc_ctrl_tb.sv ----
// register and command sequence tests of the sdram control word block
`timescale 1ns/100ps
`default_nettype none
module sdc_ctrl_tb;
	import sdc_pkg::*;
	localparam logic [31:0] BASE = 32'h0021_2000;
	localparam logic [31:0] ADDR = 32'h01D5_B3A7;
	logic              core_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic [3:0]        reg_addr = 4'h0;
	logic [31:0]       reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [31:0]       reg_rdata, rdata_b, rdata_l, rd, rdb, rdl;
	logic [3:0]        region_sdram = 4'h0;
	logic              refresh_tick = 1'b0;
	logic              acc_req = 1'b0;
	logic              acc_write = 1'b0;
	logic [1:0]        acc_region = 2'h0;
	logic [31:0]       acc_addr = 32'h0;
	logic              acc_ack, wr_lead, mem_cke, mem_cke_b, in_self, got;
	sdc_cmd_s          mem_cmd;
	sdc_cmd_s          mem_cmd_l;
	logic [12:0]       col_l = 13'h0000;
	logic [15:0]       t_last [8];
	sdc_cmd_s          c_last [8];
	logic [7:0]        n_cmd [8];
	logic [15:0]       t_lead;
	int                n_fail = 0;
	int                total_checks = 0;
	int                cw, rw, bw, cc;
	always #25 core_clk = ~core_clk;
	sdc_ctrl #(.FIRST_INST(1'b1), .LEGACY(1'b0)) u_sdc_ctrl (
		.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.region_sdram, .refresh_tick, .acc_req, .acc_write, .acc_region, .acc_addr,
		.acc_ack, .wr_lead, .mem_cmd, .mem_cke);
	sdc_ctrl #(.FIRST_INST(1'b0), .LEGACY(1'b0)) u_sdc_ctrl_b (
		.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_b),
		.region_sdram, .refresh_tick, .acc_req, .acc_write, .acc_region, .acc_addr,
		.acc_ack(), .wr_lead(), .mem_cmd(), .mem_cke(mem_cke_b));
	sdc_ctrl #(.FIRST_INST(1'b1), .LEGACY(1'b1)) u_sdc_ctrl_l (
		.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_l),
		.region_sdram, .refresh_tick, .acc_req, .acc_write, .acc_region, .acc_addr,
		.acc_ack(), .wr_lead(), .mem_cmd(mem_cmd_l), .mem_cke());
	// legacy layout column of the last read or write
	always @(posedge core_clk) begin
		if (mem_cmd_l.cmd == SDC_RD || mem_cmd_l.cmd == SDC_WR) begin
			col_l <= mem_cmd_l.addr;
		end
	end
	sdc_mem_model u_sdc_mem_model (
		.core_clk, .sys_rst, .mem_cmd, .mem_cke, .wr_lead, .t_last, .c_last, .n_cmd,
		.t_lead, .in_self);
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		rd = reg_rdata;
		rdb = rdata_b;
		rdl = rdata_l;
	endtask
	task automatic tick;
		@(posedge core_clk);
		refresh_tick <= 1'b1;
		@(posedge core_clk);
		refresh_tick <= 1'b0;
	endtask
	// request held until the column command is acknowledged or 40 cycles pass
	task automatic access(input logic w, input logic [1:0] r);
		@(posedge core_clk);
		acc_req <= 1'b1;
		acc_write <= w;
		acc_region <= r;
		acc_addr <= ADDR;
		got = 1'b0;
		for (int k = 0; k < 40 && !got; k++) begin
			@(negedge core_clk);
			got = (acc_ack === 1'b1);
			@(posedge core_clk);
		end
		acc_req <= 1'b0;
	endtask
	function automatic logic [31:0] gap(input int a, input int b);
		return 32'(t_last[a] - t_last[b]);
	endfunction
	initial begin
		#(50 * 20000);
		n_fail++;
		report_and_stop;
	end
	initial begin
		idle(20);
		sys_rst <= 1'b0;
		rd_reg(SDC_CTL_OFS);
		check("reset word", rd, 32'h0248_F000);
		check("reset word b", rdb, 32'h0248_F000);
		check("reset word legacy", rdl, 32'h0288_F000);
		check("cke at reset", 32'(mem_cke), 32'h1);
		wr_reg(SDC_CTL_OFS, 32'hFEFF_FFFF);
		rd_reg(SDC_CTL_OFS);
		check("masked word", rd, 32'h7EFF_F001);
		check("masked word b", rdb, 32'h7EFF_F001);
		check("masked word legacy", rdl, 32'h06FF_F000);
		check("cke output low", 32'(mem_cke), 32'h0);
		check("cke b stays", 32'(mem_cke_b), 32'h1);
		@(negedge core_clk);
		check("rdata after", reg_rdata, 32'h0);
		rd_reg(4'h4);
		check("unmapped", rd, 32'h0);
		wr_reg(SDC_CTL_OFS, BASE);
		idle(2);
		check("cke output high", 32'(mem_cke), 32'h1);
		region_sdram <= 4'b0101;
		wr_reg(SDC_CTL_OFS, BASE | 32'h0100_0000);
		idle(30);
		rd_reg(SDC_CTL_OFS);
		check("init clear", rd, BASE);
		check("init refs", 32'(n_cmd[5]), 32'h2);
		check("init precharge", gap(5, 4), 32'd5);
		check("init row cycle", gap(6, 5), 32'd3);
		check("mode word", 32'(c_last[6].addr), 32'h22);
		check("init regions", 32'(c_last[6].cs), 32'h5);
		check("close all", 32'(c_last[4].addr[10]), 32'h1);
		for (int j = 1; j >= 0; j--) begin
			wr_reg(SDC_CTL_OFS, BASE | (32'(j) << 25));
			tick;
			idle(10);
			check("refresh count", 32'(n_cmd[5]), 32'h3);
			check("refresh regions", 32'(c_last[5].cs), 32'h5);
		end
		for (int i = 0; i < 4; i++) begin
			cw = (i == 1) ? 8 : (i == 2) ? 10 : 9;
			rw = (i == 1) ? 12 : (i == 2) ? 13 : 11;
			bw = 1 + i % 2;
			cc = (i % 2) ? 3 : 2;
			wr_reg(SDC_CTL_OFS, BASE | (32'(i % 2) << 30) | (32'(i) << 28) | (32'(i) << 26));
			access(i % 2, 2'd2);
			idle(12);
			check("ack", 32'(got), 32'h1);
			check("column", 32'(c_last[cc].addr), ADDR & ((32'h1 << cw) - 1));
			check("bank", 32'(c_last[1].bank), (ADDR >> cw) & ((32'h1 << bw) - 1));
			check("row", 32'(c_last[1].addr), (ADDR >> (cw + bw)) & ((32'h1 << rw) - 1));
			check("column bank", 32'(c_last[cc].bank), (ADDR >> cw) & ((32'h1 << bw) - 1));
			check("legacy column", 32'(col_l), ADDR & ((32'h1 << (9 - i % 2)) - 1));
			check("act region", 32'(c_last[1].cs), 32'h4);
			check("act to column", gap(cc, 1), 32'd3);
			check("column to close", gap(4, cc), 32'd3);
			if (i % 2)
				check("data lead", 32'(t_last[3] - t_lead), 32'd1);
		end
		access(1'b0, 2'd1);
		check("foreign region", 32'(got), 32'h0);
		wr_reg(SDC_CTL_OFS, BASE | 32'h1);
		idle(12);
		check("self cke", 32'(mem_cke), 32'h0);
		check("self held", 32'(in_self), 32'h1);
		check("self precharge", gap(7, 4), 32'd2);
		check("self cke b", 32'(mem_cke_b), 32'h1);
		wr_reg(SDC_CTL_OFS, BASE);
		idle(8);
		check("self exit", 32'(mem_cke), 32'h1);
		report_and_stop;
	end
endmodule
`default_nettype wire
